// File: shared/sbc_pkg.sv
package sbc_pkg;
   // clocking
   localparam int CLK_HZ = 25_000_000;
   localparam int OSC_HZ = 6_400_000;
   localparam int OSC_DIV = (CLK_HZ + OSC_HZ / 2) / OSC_HZ;
   localparam int DIV_W = 3;
   // dead time in internal oscillator clocks
   localparam int DEAD_TICKS = 3;
   localparam int DEAD_W = 2;
   // off time reset value, programmable through the OFFT register
   localparam int OFF_TIME_US = 10;
   localparam int OFF_W = 16;
   localparam int OFF_CYCLES = (OFF_TIME_US * (CLK_HZ / 1_000_000));
   localparam logic [OFF_W-1:0] OFF_RST = OFF_W'(OFF_CYCLES);
   // current levels
   localparam logic [1:0] LVL_ZERO = 2'h0;
   localparam logic [1:0] LVL_FULL = 2'h3;
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_OFFT = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0C;
   localparam logic [7:0] OFS_LIVE = 8'h10;
   // control fields
   localparam int CTRL_EN = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   // event bits
   localparam int EV_W = 3;
   localparam int EV_OT = 0;
   localparam int EV_OC = 1;
   localparam int EV_WARN = 2;
   localparam logic [EV_W-1:0] MASK_RST = 3'h0;
   // input sync width
   localparam int SYNC_W = 16;
endpackage : sbc_pkg

// File: shared/sbc_ch_if.sv
`timescale 1ns/100ps
interface sbc_ch_if;
   import sbc_pkg::*;
   logic tick;
   logic dir;
   logic [1:0] lvl;
   logic brake;
   logic cc_off;
   logic chop_trip;
   logic enable;
   logic [OFF_W-1:0] off_cycles;
   logic pos;
   logic neg;
   logic [1:0] cur;
   modport ctl(output tick, dir, lvl, brake, cc_off, chop_trip, enable, off_cycles,
      input pos, neg, cur);
   modport chan(input tick, dir, lvl, brake, cc_off, chop_trip, enable, off_cycles,
      output pos, neg, cur);
endinterface : sbc_ch_if

// File: rtl/sbc_sync.sv
`timescale 1ns/100ps
module sbc_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : sbc_sync

// File: rtl/sbc_chan.sv
`timescale 1ns/100ps
module sbc_chan import sbc_pkg::*; (
   input wire logic mclk,
   input wire logic rst_n,
   sbc_ch_if.chan ch
);
   logic dir_used_r;
   logic dead_act_r;
   logic [DEAD_W-1:0] dead_r;
   logic [OFF_W-1:0] off_r;
   logic pos_r;
   logic neg_r;
   logic [1:0] cur_r;
   wire [1:0] lvl_eff;
   wire all_on;
   wire drive;
   wire pos_nxt;
   wire neg_nxt;
   wire dead_end;
   assign lvl_eff = ch.brake ? LVL_FULL : ch.lvl;
   assign all_on = ch.brake & ch.cc_off;
   assign drive = !dead_act_r && off_r == '0 && lvl_eff != LVL_ZERO;
   assign pos_nxt = ch.enable & (all_on | (drive & dir_used_r));
   assign neg_nxt = ch.enable & (all_on | (drive & !dir_used_r));
   assign dead_end = ch.tick && dead_r == DEAD_W'(DEAD_TICKS - 1);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dir_used_r <= 1'b0;
         dead_act_r <= 1'b0;
         dead_r <= '0;
      end else if (!dead_act_r) begin
         dead_act_r <= ch.dir != dir_used_r;
         dead_r <= '0;
      end else if (dead_end) begin
         dead_act_r <= 1'b0;
         dir_used_r <= ch.dir;
      end else if (ch.tick) begin
         dead_r <= dead_r + 1'b1;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         off_r <= '0;
      end else if (ch.cc_off || !ch.enable) begin
         off_r <= '0;
      end else if (off_r != '0) begin
         off_r <= off_r - 1'b1;
      end else if (ch.chop_trip) begin
         off_r <= ch.off_cycles;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pos_r <= 1'b0;
         neg_r <= 1'b0;
         cur_r <= LVL_ZERO;
      end else begin
         pos_r <= pos_nxt;
         neg_r <= neg_nxt;
         cur_r <= lvl_eff;
      end
   end
   assign ch.pos = pos_r;
   assign ch.neg = neg_r;
   assign ch.cur = cur_r;
endmodule : sbc_chan

// File: rtl/sbc_top.sv
`timescale 1ns/100ps
// Behaviour
// - brake input high brakes, low runs normally
// - constant current brake: full scale, sign from direction input
// - direction change during brake moves current to other side
// - during brake level-select inputs ignored, full current used
// - brake with chopping disabled turns all four switches on
// - standby input low enters low power, high runs
// - standby low or supply reapplied clears latched faults
// - fault flag open drain, pulled low once fault detected
// - fault flag releases only by standby or supply reapply
// - thermal warning pulls low when hot, releases by itself
// - direction toggle: both switches off about three oscillator clocks
// - off time from the OFFT register after each chopping event
// - reference tied to regulator disables chopping
// - trips turn all switches off and stay latched
// - high direction selects positive side, low negative
module sbc_top import sbc_pkg::*; (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic irq,
   input wire logic direction_select_a,
   input wire logic direction_select_b,
   input wire logic level_select_hi_a,
   input wire logic level_select_lo_a,
   input wire logic level_select_hi_b,
   input wire logic level_select_lo_b,
   input wire logic low_power_select_n,
   input wire logic brake_select,
   input wire logic vref_at_vcc,
   input wire logic chop_trip_a,
   input wire logic chop_trip_b,
   input wire logic over_temperature_trip,
   input wire logic overcurrent_trip,
   input wire logic thermal_alarm_hot,
   input wire logic motor_supply_ok,
   input wire logic fault_flag_in,
   output logic fault_flag_out,
   output logic fault_flag_oe,
   input wire logic thermal_warning_in,
   output logic thermal_warning_out,
   output logic thermal_warning_oe,
   output logic drive_a_pos,
   output logic drive_a_neg,
   output logic drive_b_pos,
   output logic drive_b_neg,
   output logic [1:0] cur_level_a,
   output logic [1:0] cur_level_b
);
   logic rst_meta_r;
   logic rst_n;
   logic [SYNC_W-1:0] pins_s;
   logic [DIV_W-1:0] div_r;
   logic tick_r;
   logic fault_ot_r;
   logic fault_oc_r;
   logic warn_r;
   logic [31:0] ctrl_r;
   logic [OFF_W-1:0] offt_r;
   logic [EV_W-1:0] stat_r;
   logic [EV_W-1:0] stat_nxt;
   logic [EV_W-1:0] mask_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;
   wire dir_a_s, dir_b_s, hi_a_s, lo_a_s, hi_b_s, lo_b_s;
   wire low_power_select_n_s, brake_s, cc_off_s, trip_a_s, trip_b_s;
   wire ot_s, oc_s, hot_s, sup_s, ffl_s, twl_s;
   wire standby;
   wire fault_clr;
   wire fault_any;
   wire run_en;
   wire addr_ok;
   wire rd_stat;
   wire [EV_W-1:0] ev;
   wire [31:0] rd_mux;
   wire [31:0] live_w;
   sbc_ch_if ch_a ();
   sbc_ch_if ch_b ();

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
      is_reg = a == ofs;
   endfunction : is_reg

   // reset release through two flops
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   sbc_sync #(.W(SYNC_W)) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .d({direction_select_a, direction_select_b, level_select_hi_a, level_select_lo_a,
         level_select_hi_b, level_select_lo_b, low_power_select_n, brake_select,
         vref_at_vcc, chop_trip_a, chop_trip_b, over_temperature_trip,
         overcurrent_trip, thermal_alarm_hot, motor_supply_ok,
         fault_flag_in ^ thermal_warning_in}),
      .q(pins_s)
   );
   assign {dir_a_s, dir_b_s, hi_a_s, lo_a_s, hi_b_s, lo_b_s, low_power_select_n_s, brake_s,
      cc_off_s, trip_a_s, trip_b_s, ot_s, oc_s, hot_s, sup_s, ffl_s} = pins_s;
   assign twl_s = 1'b0;

   // internal oscillator enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= div_r == DIV_W'(OSC_DIV - 1);
         div_r <= (div_r == DIV_W'(OSC_DIV - 1)) ? '0 : div_r + 1'b1;
      end
   end

   assign standby = !low_power_select_n_s;
   assign fault_clr = standby | !sup_s;
   assign fault_any = fault_ot_r | fault_oc_r;
   assign run_en = !standby && !fault_any && ctrl_r[CTRL_EN];

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fault_ot_r <= 1'b0;
         fault_oc_r <= 1'b0;
      end else if (fault_clr) begin
         fault_ot_r <= 1'b0;
         fault_oc_r <= 1'b0;
      end else begin
         fault_ot_r <= fault_ot_r | ot_s;
         fault_oc_r <= fault_oc_r | oc_s;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         warn_r <= 1'b0;
      end else begin
         warn_r <= hot_s;
      end
   end

   assign fault_flag_out = 1'b0;
   assign fault_flag_oe = fault_any;
   assign thermal_warning_out = 1'b0;
   assign thermal_warning_oe = warn_r;

   // channel hookup
   // brake from pin
   assign ch_a.tick = tick_r;
   assign ch_a.dir = dir_a_s;
   assign ch_a.lvl = {hi_a_s, lo_a_s};
   assign ch_a.brake = brake_s;
   assign ch_a.cc_off = cc_off_s;
   assign ch_a.chop_trip = trip_a_s;
   assign ch_a.enable = run_en;
   assign ch_a.off_cycles = offt_r;
   assign ch_b.tick = tick_r;
   assign ch_b.dir = dir_b_s;
   assign ch_b.lvl = {hi_b_s, lo_b_s};
   assign ch_b.brake = brake_s;
   assign ch_b.cc_off = cc_off_s;
   assign ch_b.chop_trip = trip_b_s;
   assign ch_b.enable = run_en;
   assign ch_b.off_cycles = offt_r;

   sbc_chan u_chan_a (
      .mclk(mclk),
      .rst_n(rst_n),
      .ch(ch_a.chan)
   );
   sbc_chan u_chan_b (
      .mclk(mclk),
      .rst_n(rst_n),
      .ch(ch_b.chan)
   );

   assign drive_a_pos = ch_a.pos;
   assign drive_a_neg = ch_a.neg;
   assign drive_b_pos = ch_b.pos;
   assign drive_b_neg = ch_b.neg;
   assign cur_level_a = ch_a.cur;
   assign cur_level_b = ch_b.cur;

   // events and interrupt
   assign ev[EV_OT] = ot_s & !fault_ot_r & !fault_clr;
   assign ev[EV_OC] = oc_s & !fault_oc_r & !fault_clr;
   assign ev[EV_WARN] = hot_s & !warn_r;
   assign addr_ok = hsel & htrans[1] & hready;
   assign rd_stat = addr_ok & !hwrite & is_reg(haddr[7:0], OFS_STAT);
   assign stat_nxt = (stat_r & ~(rd_stat ? {EV_W{1'b1}} : {EV_W{1'b0}})) | ev;
   assign irq = |(stat_r & mask_r);

   // live state view
   assign live_w = {19'h0, ffl_s, twl_s, ch_b.neg, ch_b.pos, ch_a.neg, ch_a.pos,
      cc_off_s, brake_s, standby, warn_r, fault_oc_r, fault_ot_r, run_en};

   assign rd_mux = is_reg(haddr[7:0], OFS_CTRL) ? ctrl_r :
      is_reg(haddr[7:0], OFS_OFFT) ? {{(32 - OFF_W){1'b0}}, offt_r} :
      is_reg(haddr[7:0], OFS_STAT) ? {{(32 - EV_W){1'b0}}, stat_r} :
      is_reg(haddr[7:0], OFS_MASK) ? {{(32 - EV_W){1'b0}}, mask_r} :
      is_reg(haddr[7:0], OFS_LIVE) ? live_w : 32'h0000_0000;

   // bus address phase
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else begin
         wr_pend_r <= addr_ok & hwrite;
         if (addr_ok) begin
            wr_addr_r <= haddr[7:0];
         end
         if (addr_ok && !hwrite) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   // register writes in data phase
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         offt_r <= OFF_RST;
         mask_r <= MASK_RST;
      end else if (wr_pend_r) begin
         if (is_reg(wr_addr_r, OFS_CTRL)) begin
            ctrl_r <= {31'h0, hwdata[CTRL_EN]};
         end
         if (is_reg(wr_addr_r, OFS_OFFT)) begin
            offt_r <= hwdata[OFF_W-1:0];
         end
         if (is_reg(wr_addr_r, OFS_MASK)) begin
            mask_r <= hwdata[EV_W-1:0];
         end
      end
   end

   // sticky status, set wins over read clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= '0;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
endmodule : sbc_top

// File: bench/sbc_host.sv
`timescale 1ns/100ps
module sbc_host #(
   parameter int WAKE = 250
) (
   input wire logic mclk,
   input wire logic [7:0] want,
   input wire logic fault_flag_oe,
   input wire logic thermal_warning_oe,
   output logic [7:0] pins,
   output logic fault_flag_in,
   output logic thermal_warning_in
);
   int wake_cnt = 0;
   // pull-ups on the open-drain pads
   assign fault_flag_in = !fault_flag_oe;
   assign thermal_warning_in = !thermal_warning_oe;
   initial pins = 8'h00;
   always @(posedge mclk) begin
      if (want[7] && !pins[7]) begin
         pins[7] <= 1'b1;
         wake_cnt <= WAKE;
      end else if (wake_cnt > 0) begin
         wake_cnt <= wake_cnt - 1;
      end else begin
         pins <= want;
      end
   end
endmodule : sbc_host

// File: bench/sbc_top_asserts.sv
`timescale 1ns/100ps
module sbc_checker (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic low_power_select_n,
   input wire logic motor_supply_ok,
   input wire logic overcurrent_trip,
   input wire logic over_temperature_trip,
   input wire logic brake_select,
   input wire logic vref_at_vcc,
   input wire logic direction_select_a,
   input wire logic thermal_alarm_hot,
   input wire logic fault_flag_out,
   input wire logic fault_flag_oe,
   input wire logic thermal_warning_out,
   input wire logic thermal_warning_oe,
   input wire logic drive_a_pos,
   input wire logic drive_a_neg,
   input wire logic drive_b_pos,
   input wire logic drive_b_neg,
   input wire logic [1:0] cur_level_a,
   input wire logic [1:0] cur_level_b
);
   logic [3:0] quiet_r;
   logic [3:0] quiet_nxt;
   logic [3:0] drv;
   assign drv = {drive_a_pos, drive_a_neg, drive_b_pos, drive_b_neg};
   // cycles since standby high and supply present
   assign quiet_nxt = !(low_power_select_n && motor_supply_ok) ? 4'h0 :
      (quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         quiet_r <= 4'h0;
      end else begin
         quiet_r <= quiet_nxt;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   pin_low_a: assert property (!fault_flag_out && !thermal_warning_out)
      else $error("open-drain pin driven high");
   trip_latch_a: assert property (quiet_r == 4'hF &&
      ($past(overcurrent_trip, 5) || $past(over_temperature_trip, 5)) |-> fault_flag_oe)
      else $error("trip not latched");
   hold_fault_a: assert property ($fell(fault_flag_oe) |-> quiet_r < 4'h6)
      else $error("fault flag released without clear");
   fault_off_a: assert property (fault_flag_oe [*2] |-> drv == 4'h0)
      else $error("switch on while fault latched");
   low_power_select_off_a: assert property (!low_power_select_n [*4] |-> drv == 4'h0)
      else $error("switch on in standby");
   brake_lvl_a: assert property ((brake_select && quiet_r == 4'hF && !fault_flag_oe) [*4]
      |-> cur_level_a == 2'h3 && cur_level_b == 2'h3)
      else $error("brake level not full");
   all_on_a: assert property ((brake_select && vref_at_vcc && quiet_r == 4'hF
      && !fault_flag_oe) [*4] |-> drv == 4'hF)
      else $error("brake without chopping not all on");
   no_shoot_a: assert property (drive_a_pos && drive_a_neg
      |-> $past(vref_at_vcc, 3) && $past(brake_select, 3))
      else $error("both sides of channel a on");
   dead_a: assert property (quiet_r == 4'hF && !vref_at_vcc && $changed(direction_select_a)
      |-> ##4 (!drive_a_pos && !drive_a_neg) [*8])
      else $error("dead time too short");
   warn_a: assert property (quiet_r == 4'hF |->
      thermal_warning_oe == $past(thermal_alarm_hot, 3))
      else $error("warning does not follow alarm");
endmodule : sbc_checker
bind sbc_top sbc_checker chk (.mclk, .rstn, .low_power_select_n, .motor_supply_ok,
   .overcurrent_trip, .over_temperature_trip, .brake_select, .vref_at_vcc, .direction_select_a,
   .thermal_alarm_hot, .fault_flag_out, .fault_flag_oe, .thermal_warning_out, .thermal_warning_oe,
   .drive_a_pos, .drive_a_neg, .drive_b_pos, .drive_b_neg, .cur_level_a, .cur_level_b);

// File: bench/test_stepper_brake_standby_fault_ctrl.sv
`timescale 1ns/100ps
module test_stepper_brake_standby_fault_ctrl import sbc_pkg::*; ();
   logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0, cur_level_a, cur_level_b;
   logic [2:0] hsize = 3'h2;
   logic [7:0] want = 8'h00, pins;
   logic vref_at_vcc = 1'b0, chop_trip_a = 1'b0, chop_trip_b = 1'b0;
   logic over_temperature_trip = 1'b0, overcurrent_trip = 1'b0;
   logic thermal_alarm_hot = 1'b0, motor_supply_ok = 1'b1;
   logic hready, hreadyout, hresp, irq, fault_flag_in, fault_flag_out, fault_flag_oe;
   logic thermal_warning_in, thermal_warning_out, thermal_warning_oe;
   logic drive_a_pos, drive_a_neg, drive_b_pos, drive_b_neg;
   logic direction_select_a, direction_select_b, level_select_hi_a, level_select_lo_a;
   logic level_select_hi_b, level_select_lo_b, low_power_select_n, brake_select;
   logic [3:0] drv;
   int miscompares = 0, check_count = 0;
   assign hready = hreadyout;
   assign drv = {drive_a_pos, drive_a_neg, drive_b_pos, drive_b_neg};
   assign {low_power_select_n, brake_select, level_select_lo_b, level_select_hi_b,
      level_select_lo_a, level_select_hi_a, direction_select_b, direction_select_a} = pins;
   sbc_host host (.mclk, .want, .fault_flag_oe, .thermal_warning_oe, .pins, .fault_flag_in,
      .thermal_warning_in);
   sbc_top dut (.*);
   always #20 mclk = ~mclk;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge mclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : ahb

   task automatic give_verdict;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      give_verdict();
   end

   initial begin
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      cyc(3);
      ahb(1'b0, OFS_CTRL, 32'h0, rd);
      check("ctrl", rd, CTRL_RST);
      ahb(1'b0, OFS_OFFT, 32'h0, rd);
      check("offt", rd, 32'(OFF_RST));
      ahb(1'b0, OFS_STAT, 32'h0, rd);
      check("stat", rd, 32'h0);
      ahb(1'b0, OFS_MASK, 32'h0, rd);
      check("mask", rd, 32'h0);
      ahb(1'b1, 8'h20, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 8'h20, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      ahb(1'b1, OFS_OFFT, 32'h14, rd);
      ahb(1'b0, OFS_OFFT, 32'h0, rd);
      check("offt wr", rd, 32'h14);
      check("hresp", 32'(hresp), 32'h0);
      $display("test registers done");
      want <= 8'hBD;
      cyc(300);
      check("run", 32'(drv), 32'h9);
      check("lvl", 32'(cur_level_a), 32'h3);
      want <= 8'hBC;
      cyc(8);
      check("dead", 32'(drv), 32'h1);
      cyc(22);
      check("new side", 32'(drv), 32'h5);
      chop_trip_a <= 1'b1;
      chop_trip_b <= 1'b1;
      cyc(1);
      chop_trip_a <= 1'b0;
      chop_trip_b <= 1'b0;
      cyc(8);
      check("off time", 32'(drv), 32'h0);
      cyc(40);
      check("off end", 32'(drv), 32'h5);
      $display("test direction done");
      want <= 8'hD8;
      cyc(30);
      check("brake neg", 32'(drv), 32'h5);
      check("brake lvl", 32'({cur_level_a, cur_level_b}), 32'hF);
      want <= 8'hDB;
      cyc(30);
      check("brake flip", 32'(drv), 32'hA);
      want <= 8'h83;
      cyc(30);
      check("no brake", 32'(drv), 32'h0);
      check("zero lvl", 32'({cur_level_a, cur_level_b}), 32'h0);
      vref_at_vcc <= 1'b1;
      want <= 8'hC3;
      cyc(30);
      check("all on", 32'(drv), 32'hF);
      want <= 8'hBF;
      cyc(30);
      chop_trip_a <= 1'b1;
      cyc(1);
      chop_trip_a <= 1'b0;
      cyc(8);
      check("no chop", 32'(drv), 32'hA);
      vref_at_vcc <= 1'b0;
      $display("test brake done");
      ahb(1'b1, OFS_MASK, 32'h7, rd);
      overcurrent_trip <= 1'b1;
      cyc(1);
      overcurrent_trip <= 1'b0;
      cyc(8);
      check("flag low", 32'(fault_flag_in), 32'h0);
      check("trip off", 32'(drv), 32'h0);
      check("irq", 32'(irq), 32'h1);
      ahb(1'b0, OFS_STAT, 32'h0, rd);
      check("stat oc", rd, 32'h2);
      cyc(1);
      check("irq clr", 32'(irq), 32'h0);
      cyc(20);
      check("flag held", 32'(fault_flag_oe), 32'h1);
      want <= 8'h3F;
      cyc(8);
      check("low_power_select clr", 32'(fault_flag_oe), 32'h0);
      want <= 8'hBF;
      cyc(300);
      check("wake", 32'(drv), 32'hA);
      ahb(1'b1, OFS_MASK, 32'h0, rd);
      over_temperature_trip <= 1'b1;
      cyc(1);
      over_temperature_trip <= 1'b0;
      cyc(8);
      check("ot flag", 32'(fault_flag_oe), 32'h1);
      check("irq mask", 32'(irq), 32'h0);
      ahb(1'b0, OFS_STAT, 32'h0, rd);
      check("stat ot", rd, 32'h1);
      motor_supply_ok <= 1'b0;
      cyc(5);
      motor_supply_ok <= 1'b1;
      cyc(8);
      check("supply clr", 32'(fault_flag_oe), 32'h0);
      $display("test faults done");
      thermal_alarm_hot <= 1'b1;
      cyc(8);
      check("warn", 32'(thermal_warning_in), 32'h0);
      ahb(1'b0, OFS_STAT, 32'h0, rd);
      check("stat warn", rd, 32'h4);
      thermal_alarm_hot <= 1'b0;
      cyc(8);
      check("warn rel", 32'(thermal_warning_in), 32'h1);
      $display("test warning done");
      give_verdict();
   end
endmodule : test_stepper_brake_standby_fault_ctrl
